/* File: shared/sbs_defines.svh */
// startup sequencer constants: field widths, timing counts, encodings
// assumes mclk at 25 MHz; included by the design files
`ifndef SBS_DEFINES_SVH
`define SBS_DEFINES_SVH

`define SBS_CLK_HZ          25000000
`define SBS_WM_TIMEOUT_MS   300
`define SBS_WM_TIMEOUT_CYC  ((`SBS_CLK_HZ / 1000) * `SBS_WM_TIMEOUT_MS)
`define SBS_SYNC_EVENTS     3
`define SBS_DUTY_HALF       10'h200
`define SBS_DUTY_W          10
`define SBS_FREQ_W          10
`define SBS_MS_CYC          (`SBS_CLK_HZ / 1000)
`define SBS_SPD_SAT_PER     ((`SBS_MS_CYC * 8) / 1024)
`define SBS_PWM_PERIOD_CYC  1250
`define SBS_KM_BASE         6'h06
`define SBS_KM_MAX          4'hF
`define SBS_RB_SPEED        3'h1
`define SBS_RB_STATE        3'h2
`define SBS_RB_FREQ         3'h3

`endif

/* File: shared/sbs_pkg.sv */
// types of the startup sequencer
// assumes sbs_defines.svh is on the include path
package sbs_pkg;

    typedef enum logic [8:0] {
        ST_IDLE    = 9'h001,
        ST_WATCH   = 9'h002,
        ST_BRAKE   = 9'h004,
        ST_ALIGN   = 9'h008,
        ST_RAMP    = 9'h010,
        ST_COAST   = 9'h020,
        ST_CLOSED  = 9'h040,
        ST_LOSTSYN = 9'h080,
        ST_HOLD    = 9'h100
    } sbs_state_e;

    typedef logic [9:0] sbs_duty_t;

endpackage : sbs_pkg

/* File: design/sbs_edge_filter.sv */
// bemf crossing qualifier: three-flop sync then persistence filter
// assumes an asynchronous crossing input and a filter time in cycles
`timescale 1ns/1ps
`include "sbs_defines.svh"

module sbs_edge_filter (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        raw_in,
    input  wire logic [15:0] filt_cycles,
    output logic             event_pulse
);
    logic [2:0]  sync_q, sync_d;
    logic        level_q, level_d;
    logic [15:0] cnt_q, cnt_d;
    logic        ev_q, ev_d;

    // -----------------------------------------------------------------
    // filter: a change must persist for filt_cycles before it counts
    // -----------------------------------------------------------------
    always_comb begin
        sync_d  = {sync_q[1:0], raw_in};
        level_d = level_q;
        cnt_d   = cnt_q;
        ev_d    = 1'b0;
        if (sync_q[2] == sync_q[1] && sync_q[2] != level_q) begin
            if (cnt_q >= filt_cycles) begin
                level_d = sync_q[2];
                cnt_d   = 16'h0000;
                ev_d    = 1'b1;
            end else begin
                cnt_d = cnt_q + 16'h0001;
            end
        end else begin
            cnt_d = 16'h0000;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync_q  <= 3'h0;
            level_q <= 1'b0;
            cnt_q   <= 16'h0000;
            ev_q    <= 1'b0;
        end else begin
            sync_q  <= sync_d;
            level_q <= level_d;
            cnt_q   <= cnt_d;
            ev_q    <= ev_d;
        end
    end

    assign event_pulse = ev_q;

endmodule : sbs_edge_filter

/* File: design/sbs_startup_seq.sv */
// sensorless bldc startup sequencer: windmill check, brake, align, ramp,
// coast/sync, closed-loop handover and loss-of-sync supervision
// assumes config ports are static or change slowly; bemf crossings async
//
// Contract
// - speed above overspeed limit enters loss-of-sync, then stop or restart
// - normal start: align, open-loop ramp, coast, then closed loop
// - hold_time sets align length; zero skips alignment
// - two-phase align: A half hold duty, B zero, C full
// - three-phase align: A 50%, B 50% minus half, C plus half
// - align duty ramps over 0/25/50/100% of hold then holds
// - current limit stays active through the alignment hold
// - open-loop drive ignores position; waveform_select 0 sine, 1 trapezoid
// - ramp frequency starts at start freq, steps by increment per step time
// - ramp duty rises linearly from start duty to end duty
// - coast: outputs off, three sync events, then closed loop
// - coast disabled: ramp passes straight to closed loop
// - resume duty equals freq over 0.1 times motor constant over 1023
// - speed count shown on readback when selector is 001
// - prerotation check: crossings count only after filter time
// - no crossings in 300 ms or slow speed: normal start
// - reverse prerotation: pulse low sides at brake duty until slow
// - forward prerotation: skip align and ramp, go to coast
// - offers voltage, current and speed modes from live config
// - standalone mode takes demand from external pwm duty
// - speed readable during prerotation detection
// - speed below underspeed limit enters loss-of-sync
// - run cleared forces all gates low, overriding everything
`timescale 1ns/1ps
`include "sbs_defines.svh"

module sbs_startup_seq (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        run,
    input  wire logic        direction,
    input  wire logic        brake_request,
    input  wire logic        standalone_select,
    input  wire logic [9:0]  demand_input,
    input  wire logic [9:0]  pwm_demand,
    input  wire logic [1:0]  control_mode,
    input  wire logic        three_phase_mod,
    input  wire logic        current_limit_en,
    input  wire logic        restart_en,
    input  wire logic [3:0]  overspeed_limit,
    input  wire logic [3:0]  underspeed_limit,
    input  wire logic [3:0]  hold_time,
    input  wire logic [4:0]  hold_duty,
    input  wire logic [1:0]  align_rise_fraction,
    input  wire logic        waveform_select,
    input  wire logic [3:0]  ramp_start_freq,
    input  wire logic [3:0]  ramp_end_freq,
    input  wire logic [3:0]  speed_increment,
    input  wire logic [3:0]  ramp_step_time,
    input  wire logic [3:0]  ramp_start_duty,
    input  wire logic [3:0]  ramp_end_duty,
    input  wire logic        coast_enable,
    input  wire logic [3:0]  motor_constant,
    input  wire logic [2:0]  speed_resolution,
    input  wire logic [2:0]  readback_select,
    input  wire logic        prerotation_enable,
    input  wire logic [15:0] bemf_filter_time,
    input  wire logic [2:0]  min_prerotation_freq,
    input  wire logic [3:0]  reverse_brake_duty,
    input  wire logic        bemf_crossing,
    input  wire logic        bemf_reverse,
    input  wire logic [9:0]  closed_loop_freq,
    output logic [9:0]       duty_a,
    output logic [9:0]       duty_b,
    output logic [9:0]       duty_c,
    output logic             gates_enable,
    output logic             low_side_brake,
    output logic             open_loop,
    output logic             waveform_trap,
    output logic             current_limit_active,
    output logic             closed_loop,
    output logic [1:0]       active_mode,
    output logic [9:0]       demand_value,
    output logic [9:0]       ol_freq,
    output logic [9:0]       peak_duty,
    output logic             loss_of_sync,
    output logic [9:0]       readback_data
);
    sbs_pkg::sbs_state_e st_q, st_d;
    logic [23:0] tmr_q, tmr_d;      // generic phase timer
    logic [23:0] per_q, per_d;      // cycles since last crossing
    logic [9:0]  freq_q, freq_d;    // open-loop frequency, Hz
    logic [9:0]  spd_q, spd_d;      // measured speed count n
    logic [1:0]  sync_q, sync_d;
    logic [9:0]  pk_q, pk_d;
    logic        rev_q, rev_d;
    logic        lost_q, lost_d;
    logic [9:0]  da_q, db_q, dc_q, da_d, db_d, dc_d;
    logic [9:0]  rb_q, rb_d;
    logic        xing;
    logic [23:0] hold_cyc, rise_cyc, step_cyc;
    logic [9:0]  hd10, sd1, sd2, f_end, meas_hz, os_hz, us_hz, wm_hz;
    logic [19:0] km_prod, spd_prod;
    logic [23:0] ramp_span, ramp_pos;

    // qualified crossings of the bemf comparator
    sbs_edge_filter u_filt (
        .mclk        (mclk),
        .rst         (rst),
        .raw_in      (bemf_crossing),
        .filt_cycles (bemf_filter_time),
        .event_pulse (xing)
    );

    // -----------------------------------------------------------------
    // scaled configuration values
    // -----------------------------------------------------------------
    always_comb begin
        hold_cyc = 24'(hold_time) * 24'(`SBS_MS_CYC) * 24'd40;        // 40 ms steps, fits 24 bits
        unique case (align_rise_fraction)
            2'h0:    rise_cyc = 24'h000000;
            2'h1:    rise_cyc = hold_cyc >> 2;
            2'h2:    rise_cyc = hold_cyc >> 1;
            default: rise_cyc = hold_cyc;
        endcase
        step_cyc = (24'(ramp_step_time) + 24'h1) * 24'(`SBS_MS_CYC) * 24'd10;
        hd10     = {hold_duty, 5'h00};
        sd1      = {ramp_start_duty, 6'h00};
        sd2      = {ramp_end_duty, 6'h3F};
        f_end    = {ramp_end_freq, 4'h0};
        spd_prod = 20'(spd_q) * (20'(speed_resolution) + 20'h1);
        meas_hz  = (spd_prod > 20'h003FF) ? 10'h3FF : spd_prod[9:0];
        os_hz    = {overspeed_limit, 6'h3F};
        us_hz    = {2'h0, underspeed_limit, 4'h0};
        wm_hz    = {3'h0, min_prerotation_freq, 4'h0};
        // duty = f/0.1 * km / 1023, km = 0.3 + 0.05*code, in tenths of percent
        km_prod  = 20'(meas_hz) * (20'(`SBS_KM_BASE) + 20'(motor_constant)) / 20'd2;
        ramp_span = 24'(f_end > {ramp_start_freq, 4'h0} ? f_end - {ramp_start_freq, 4'h0}
                                                         : 10'h001);
        ramp_pos  = 24'(freq_q > {ramp_start_freq, 4'h0} ? freq_q - {ramp_start_freq, 4'h0}
                                                          : 10'h000);
    end

    // -----------------------------------------------------------------
    // sequencer next state
    // -----------------------------------------------------------------
    always_comb begin
        st_d   = st_q;
        tmr_d  = tmr_q + 24'h1;
        per_d  = (per_q == 24'hFFFFFF) ? per_q : per_q + 24'h1;
        freq_d = freq_q;
        spd_d  = spd_q;
        sync_d = sync_q;
        pk_d   = pk_q;
        rev_d  = rev_q;
        lost_d = lost_q;
        if (xing) begin
            // speed count from crossing period, crossings per 8 ms
            spd_d = (per_q <= 24'(`SBS_SPD_SAT_PER)) ? 10'h3FF
                                                       : 10'(24'(`SBS_MS_CYC) * 24'd8 / per_q);
            per_d = 24'h0;
            rev_d = bemf_reverse;
        end
        unique case (st_q)
            sbs_pkg::ST_IDLE: begin
                tmr_d  = 24'h0;
                sync_d = 2'h0;
                if (run && !brake_request) begin
                    lost_d = 1'b0;
                    st_d   = prerotation_enable ? sbs_pkg::ST_WATCH
                                                : sbs_pkg::ST_ALIGN;
                end
            end
            sbs_pkg::ST_WATCH: begin
                if (tmr_q >= 24'(`SBS_WM_TIMEOUT_CYC)) begin
                    tmr_d = 24'h0;
                    st_d  = sbs_pkg::ST_ALIGN;
                end else if (xing && sync_q == 2'h2) begin
                    if (meas_hz < wm_hz) begin
                        tmr_d = 24'h0;
                        st_d  = sbs_pkg::ST_ALIGN;
                    end else if (bemf_reverse != direction) begin
                        st_d  = sbs_pkg::ST_BRAKE;
                    end else begin
                        sync_d = 2'h0;
                        st_d   = sbs_pkg::ST_COAST;
                    end
                end else if (xing) begin
                    sync_d = sync_q + 2'h1;
                end
            end
            sbs_pkg::ST_BRAKE: begin
                if (meas_hz < wm_hz || per_q >= 24'(`SBS_WM_TIMEOUT_CYC)) begin
                    tmr_d = 24'h0;
                    st_d  = sbs_pkg::ST_ALIGN;
                end
            end
            sbs_pkg::ST_ALIGN: begin
                if (tmr_q >= hold_cyc) begin
                    tmr_d  = 24'h0;
                    freq_d = {ramp_start_freq, 4'h0};
                    st_d   = sbs_pkg::ST_RAMP;
                end
            end
            sbs_pkg::ST_RAMP: begin
                pk_d = da_d;
                if (freq_q >= f_end) begin
                    tmr_d  = 24'h0;
                    sync_d = 2'h0;
                    st_d   = coast_enable ? sbs_pkg::ST_COAST
                                          : sbs_pkg::ST_CLOSED;
                end else if (tmr_q >= step_cyc) begin
                    tmr_d  = 24'h0;
                    freq_d = 10'(freq_q + {6'h00, speed_increment});
                end
            end
            sbs_pkg::ST_COAST: begin
                if (xing) begin
                    if (sync_q == 2'(`SBS_SYNC_EVENTS - 1)) begin
                        pk_d = 10'(km_prod > 20'h3FF ? 20'h3FF : km_prod);
                        st_d = sbs_pkg::ST_CLOSED;
                    end else begin
                        sync_d = sync_q + 2'h1;
                    end
                end
            end
            sbs_pkg::ST_CLOSED: begin
                if (meas_hz > os_hz || meas_hz < us_hz) begin
                    lost_d = 1'b1;
                    tmr_d  = 24'h0;
                    st_d   = sbs_pkg::ST_LOSTSYN;
                end
            end
            sbs_pkg::ST_LOSTSYN: begin
                st_d = restart_en ? sbs_pkg::ST_IDLE : sbs_pkg::ST_HOLD;
            end
            sbs_pkg::ST_HOLD: begin
                tmr_d = 24'h0;
            end
            default: st_d = sbs_pkg::ST_IDLE;
        endcase
        if (!run) begin
            st_d = sbs_pkg::ST_IDLE;
        end
    end

    // -----------------------------------------------------------------
    // phase duties for each state
    // -----------------------------------------------------------------
    always_comb begin
        logic [9:0] amp;
        amp  = 10'h000;
        da_d = 10'h000;
        db_d = 10'h000;
        dc_d = 10'h000;
        unique case (st_q)
            sbs_pkg::ST_ALIGN: begin
                if (rise_cyc == 24'h0 || tmr_q >= rise_cyc)
                    amp = hd10;
                else
                    amp = 10'((34'(hd10) * 34'(tmr_q)) / 34'(rise_cyc));
                if (three_phase_mod) begin
                    da_d = `SBS_DUTY_HALF;
                    db_d = 10'(`SBS_DUTY_HALF - (amp >> 1));
                    dc_d = 10'(`SBS_DUTY_HALF + (amp >> 1));
                end else begin
                    da_d = amp >> 1;
                    db_d = 10'h000;
                    dc_d = amp;
                end
            end
            sbs_pkg::ST_RAMP: begin
                amp  = 10'(24'(sd1) + (24'(sd2 - sd1) * ramp_pos) / ramp_span);
                da_d = amp;
                db_d = amp;
                dc_d = amp;
            end
            sbs_pkg::ST_BRAKE: begin
                da_d = {reverse_brake_duty, 6'h00};
                db_d = {reverse_brake_duty, 6'h00};
                dc_d = {reverse_brake_duty, 6'h00};
            end
            sbs_pkg::ST_CLOSED: begin
                da_d = pk_q;
                db_d = pk_q;
                dc_d = pk_q;
            end
            default: ;
        endcase
        if (!run) begin
            da_d = 10'h000;
            db_d = 10'h000;
            dc_d = 10'h000;
        end
        unique case (readback_select)
            `SBS_RB_SPEED: rb_d = spd_q;
            `SBS_RB_STATE: rb_d = {1'b0, st_q};
            `SBS_RB_FREQ:  rb_d = freq_q;
            default:       rb_d = 10'h000;
        endcase
    end

    // -----------------------------------------------------------------
    // state registers
    // -----------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_q   <= sbs_pkg::ST_IDLE;
            tmr_q  <= 24'h0;
            per_q  <= 24'hFFFFFF;
            freq_q <= 10'h000;
            spd_q  <= 10'h000;
            sync_q <= 2'h0;
            pk_q   <= 10'h000;
            rev_q  <= 1'b0;
            lost_q <= 1'b0;
            da_q   <= 10'h000;
            db_q   <= 10'h000;
            dc_q   <= 10'h000;
            rb_q   <= 10'h000;
        end else begin
            st_q   <= st_d;
            tmr_q  <= tmr_d;
            per_q  <= per_d;
            freq_q <= freq_d;
            spd_q  <= spd_d;
            sync_q <= sync_d;
            pk_q   <= pk_d;
            rev_q  <= rev_d;
            lost_q <= lost_d;
            da_q   <= da_d;
            db_q   <= db_d;
            dc_q   <= dc_d;
            rb_q   <= rb_d;
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    assign duty_a        = da_q;
    assign duty_b        = db_q;
    assign duty_c        = dc_q;
    assign peak_duty     = pk_q;
    assign ol_freq       = freq_q;
    assign readback_data = rb_q;
    assign loss_of_sync  = lost_q;
    assign gates_enable  = run && (st_q == sbs_pkg::ST_ALIGN || st_q == sbs_pkg::ST_RAMP
                           || st_q == sbs_pkg::ST_CLOSED || st_q == sbs_pkg::ST_BRAKE);
    assign low_side_brake = run && st_q == sbs_pkg::ST_BRAKE;
    assign open_loop      = st_q == sbs_pkg::ST_RAMP;
    assign waveform_trap  = waveform_select;
    assign current_limit_active = current_limit_en && run && st_q != sbs_pkg::ST_IDLE;
    assign closed_loop    = run && st_q == sbs_pkg::ST_CLOSED;
    assign active_mode    = control_mode;
    assign demand_value   = standalone_select ? pwm_demand : demand_input;

    // closed_loop_freq is not used; it only feeds the unused_cl reduction and never reaches the readback path
    logic unused_cl;
    assign unused_cl = ^closed_loop_freq;

endmodule : sbs_startup_seq

/* File: sim/sbs_startup_seq_properties.sv */
// port checker for the startup sequencer
// assumes one mclk domain; bound onto sbs_startup_seq below
`timescale 1ns/1ps

module sbs_seq_chk (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       run,
    input wire logic [1:0] control_mode,
    input wire logic       current_limit_en,
    input wire logic [3:0] ramp_start_freq,
    input wire logic       waveform_select,
    input wire logic [9:0] duty_a,
    input wire logic [9:0] duty_b,
    input wire logic [9:0] duty_c,
    input wire logic       gates_enable,
    input wire logic       low_side_brake,
    input wire logic       open_loop,
    input wire logic       waveform_trap,
    input wire logic       current_limit_active,
    input wire logic       closed_loop,
    input wire logic [1:0] active_mode,
    input wire logic [9:0] ol_freq,
    input wire logic       loss_of_sync
);
    // ------------------
    // output properties
    // ------------------
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (rst);

    property p_run_gate;
        !run |=> !gates_enable && !low_side_brake;
    endproperty
    a_run_gate: assert property (p_run_gate) else $error("drive on with run low");
    property p_run_duty;
        !run ##1 !run |=> (duty_a | duty_b | duty_c) == 10'h000;
    endproperty
    a_run_duty: assert property (p_run_duty) else $error("duty with run low");
    property p_wave;
        open_loop |-> waveform_trap == waveform_select;
    endproperty
    a_wave: assert property (p_wave) else $error("wrong waveform shape");
    property p_mode;
        active_mode == control_mode;
    endproperty
    a_mode: assert property (p_mode) else $error("control mode not followed");
    property p_climit;
        current_limit_active |-> current_limit_en;
    endproperty
    a_climit: assert property (p_climit) else $error("limit on while disabled");
    property p_climit_align;
        gates_enable && !open_loop && !closed_loop && !low_side_brake && current_limit_en
            |-> current_limit_active;
    endproperty
    a_climit_align: assert property (p_climit_align) else $error("no limit in align");
    property p_brake;
        low_side_brake |-> !open_loop && !closed_loop;
    endproperty
    a_brake: assert property (p_brake) else $error("brake during commutation");
    property p_lost;
        $rose(loss_of_sync) |-> $past(closed_loop) || $past(closed_loop, 2);
    endproperty
    a_lost: assert property (p_lost) else $error("sync loss outside closed loop");
    property p_ramp_freq;
        $rose(open_loop) |-> ##[0:2] ol_freq == {2'h0, ramp_start_freq, 4'h0};
    endproperty
    a_ramp_freq: assert property (p_ramp_freq) else $error("ramp start freq wrong");
endmodule : sbs_seq_chk

bind sbs_startup_seq sbs_seq_chk u_chk (
    .mclk, .rst, .run, .control_mode, .current_limit_en, .ramp_start_freq,
    .waveform_select, .duty_a, .duty_b, .duty_c, .gates_enable, .low_side_brake,
    .open_loop, .waveform_trap, .current_limit_active, .closed_loop, .active_mode,
    .ol_freq, .loss_of_sync
);

/* File: sim/sbs_motor_model.sv */
// bemf crossing source standing in for the spinning motor
// assumes mclk from the bench; gap is cycles between crossings
`timescale 1ns/1ps

module sbs_motor_model (
    input  wire logic        mclk,
    input  wire logic        spin,
    input  wire logic        reverse_dir,
    input  wire logic [11:0] gap,
    output logic             bemf_crossing,
    output logic             bemf_reverse
);
    int cnt = 0;
    initial bemf_crossing = 1'b0;
    // comparator level flips once per gap while turning
    always @(posedge mclk) begin
        cnt <= (spin && cnt < gap - 1) ? cnt + 1 : 0;
        if (spin && cnt == gap - 1)
            bemf_crossing <= ~bemf_crossing;
    end
    assign bemf_reverse = reverse_dir;
endmodule : sbs_motor_model

/* File: sim/sbs_startup_seq_tb.sv */
// self-checking bench for the startup sequencer with a bemf source
// assumes design, checker and motor model compiled before this file
`timescale 1ns/1ps

module sbs_startup_seq_tb;
    logic        mclk, rst, run, direction, brake_request, standalone_select, spin, rev;
    logic        three_phase_mod, current_limit_en, restart_en, waveform_select, saw_open;
    logic        coast_enable, prerotation_enable, bemf_crossing, bemf_reverse;
    logic        gates_enable, low_side_brake, open_loop, waveform_trap, closed_loop;
    logic        current_limit_active, loss_of_sync;
    logic [1:0]  control_mode, align_rise_fraction, active_mode;
    logic [2:0]  speed_resolution, readback_select, min_prerotation_freq;
    logic [3:0]  overspeed_limit, underspeed_limit, hold_time, ramp_start_freq, ramp_end_freq;
    logic [3:0]  speed_increment, ramp_step_time, ramp_start_duty, ramp_end_duty;
    logic [3:0]  motor_constant, reverse_brake_duty;
    logic [4:0]  hold_duty;
    logic [9:0]  demand_input, pwm_demand, closed_loop_freq, duty_a, duty_b, duty_c;
    logic [9:0]  demand_value, ol_freq, peak_duty, readback_data;
    logic [11:0] gap;
    logic [15:0] bemf_filter_time;
    int          err_count = 0;
    int          checks_done = 0;

    sbs_startup_seq u_dut (.*);
    sbs_motor_model u_mot (.mclk, .spin, .reverse_dir(rev), .gap, .bemf_crossing, .bemf_reverse);

    // --------------
    // clock, tasks
    // --------------
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask : cyc

    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude

    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // wait for a flag: 0 open loop, 1 brake, 2 closed loop, 3 sync lost
    task automatic await(input int sel, input int lim);
        logic f;
        for (int i = 0; i < lim; i++) begin
            f = sel == 0 ? open_loop : sel == 1 ? low_side_brake : sel == 2 ? closed_loop
                : loss_of_sync;
            saw_open = saw_open | open_loop;
            if (f === 1'b1)
                return;
            cyc(1);
        end
        err_count++;
        $display("wrong value at %0t: wait ran out", $time);
        conclude();
    endtask : await

    // --------------
    // main sequence
    // --------------
    initial begin
        rst = 1'b1;
        {run, direction, brake_request, standalone_select, three_phase_mod, spin, rev} = '0;
        {current_limit_en, restart_en, waveform_select, prerotation_enable, saw_open} = '0;
        {control_mode, align_rise_fraction, speed_resolution, readback_select} = '0;
        {min_prerotation_freq, underspeed_limit, hold_time, hold_duty} = '0;
        {overspeed_limit, ramp_start_freq, ramp_end_freq, speed_increment} = 16'hF3F1;
        {ramp_step_time, ramp_start_duty, ramp_end_duty, motor_constant} = 16'h05F8;
        {reverse_brake_duty, coast_enable, gap, bemf_filter_time} = {5'h11, 12'h014, 16'h0004};
        {demand_input, pwm_demand, closed_loop_freq} = {10'h155, 10'h2AA, 10'h000};
        cyc(8);
        rst = 1'b0;
        for (int m = 0; m < 4; m++) begin
            control_mode = m[1:0];
            standalone_select = m[0];
            cyc(1);
            chk(10'(active_mode), 10'(m));
            chk(demand_value, m[0] ? 10'h2AA : 10'h155);
        end
        // alignment duties in both modulation forms, then a slow rise
        {hold_time, hold_duty, current_limit_en} = {4'h1, 5'h0A, 1'b1};
        for (int t = 0; t < 3; t++) begin
            three_phase_mod = t[0];
            align_rise_fraction = t[1] ? 2'h1 : 2'h0;
            run = 1'b1;
            cyc(4);
            chk(10'(current_limit_active), 10'h001);
            if (t < 2) begin
                chk(duty_a, t ? 10'h200 : 10'h0A0);
                chk(duty_b, t ? 10'h160 : 10'h000);
                chk(duty_c, t ? 10'h2A0 : 10'h140);
            end else
                chk(10'(duty_c < 10'h140), 10'h001);
            run = 1'b0;
            cyc(3);
            chk(duty_c | 10'(gates_enable), 10'h000);
        end
        // zero hold time goes straight into the open-loop ramp
        {hold_time, readback_select} = {4'h0, 3'h3};
        for (int w = 0; w < 2; w++) begin
            waveform_select = w[0];
            run = 1'b1;
            await(0, 4);
            cyc(2);
            chk(ol_freq, 10'h030);
            chk(readback_data, 10'h030);
            chk(peak_duty, 10'h140);
            chk(10'(waveform_trap), 10'(w));
            run = 1'b0;
            cyc(3);
        end
        // forward spin: coast and sync, closed loop, then overspeed
        {prerotation_enable, min_prerotation_freq, readback_select, spin} = 8'hF3;
        cyc(20);
        saw_open = 1'b0;
        run = 1'b1;
        await(2, 3000);
        chk(10'(saw_open), 10'h000);
        chk(peak_duty, 10'h3FF);
        chk(10'(readback_data != 10'h000), 10'h001);
        overspeed_limit = 4'h0;
        await(3, 3000);
        cyc(3);
        chk(10'(closed_loop | gates_enable), 10'h000);
        {run, overspeed_limit, rev} = 6'h1F;
        cyc(3);
        // reverse spin: low-side brake until slow, then normal start
        run = 1'b1;
        await(1, 3000);
        cyc(1);
        chk(duty_a, 10'h200);
        gap = 12'h7D0;
        await(0, 30000);
        {run, rev, gap, underspeed_limit, restart_en} = {2'h0, 12'h014, 4'h7, 1'b1};
        cyc(20);
        // closed loop falling under the low-speed limit
        run = 1'b1;
        await(2, 3000);
        gap = 12'h7D0;
        await(3, 30000);
        // coast off and a ramp already at its end: straight to closed loop
        {run, prerotation_enable, coast_enable, ramp_end_freq} = {3'h0, 4'h3};
        cyc(3);
        saw_open = 1'b0;
        run = 1'b1;
        await(2, 10);
        chk(10'(saw_open), 10'h001);
        conclude();
    end
endmodule : sbs_startup_seq_tb
